// file: watchdog_pkg.sv
package watchdog_pkg;

	//--------------------------------------------------------------
	// Command codes and widths
	//--------------------------------------------------------------
	localparam int          CMD_W                  = 12;
	localparam int          CODE_W                 = 3;
	localparam logic [11:0] ARM_COMMAND            = 12'h900;
	localparam logic [11:0] DISARM_COMMAND         = 12'h901;
	localparam logic [11:0] KICK_COMMAND           = 12'h902;
	localparam logic [11:0] READ_PERIOD_COMMAND    = 12'h903;
	localparam logic [11:0] WRITE_PERIOD_COMMAND   = 12'h904;
	localparam logic [11:0] HOST_KICK_MODE_COMMAND = 12'h905;

	//--------------------------------------------------------------
	// Period selection codes and reset value
	//--------------------------------------------------------------
	localparam logic [2:0] CODE_2S    = 3'h0;
	localparam logic [2:0] CODE_5S    = 3'h1;
	localparam logic [2:0] CODE_10S   = 3'h2;
	localparam logic [2:0] CODE_15S   = 3'h3;
	localparam logic [2:0] CODE_30S   = 3'h4;
	localparam logic [2:0] CODE_RESET = CODE_5S;

	//--------------------------------------------------------------
	// Timing
	//--------------------------------------------------------------
	localparam longint CLK_HZ      = 250000000;
	localparam longint PERIOD_2S   = 2;
	localparam longint PERIOD_5S   = 5;
	localparam longint PERIOD_10S  = 10;
	localparam longint PERIOD_15S  = 15;
	localparam longint PERIOD_30S  = 30;
	localparam longint PERIOD_40S  = 40;
	localparam int     CNT_W       = 34;
	localparam longint RESET_PULSE_NS = 40;
	localparam longint CLK_NS      = 4;
	localparam int     RESET_PULSE_CYC = int'((RESET_PULSE_NS + CLK_NS - 1) / CLK_NS);
	localparam int     PULSE_W     = 8;

	//--------------------------------------------------------------
	// Carriers
	//--------------------------------------------------------------
	typedef struct packed {
		logic              valid;
		logic [CMD_W-1:0]  code;
		logic [CODE_W-1:0] data;
	} command_t;

	typedef struct packed {
		logic              valid;
		logic [CODE_W-1:0] data;
	} reply_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SELF,
		ST_HOST
	} wd_state_t;

endpackage

// file: period_counter.sv
`timescale 1ns/1ps
module period_counter
	import watchdog_pkg::*;
#(
	parameter longint TICKS_2S  = PERIOD_2S * CLK_HZ,
	parameter longint TICKS_5S  = PERIOD_5S * CLK_HZ,
	parameter longint TICKS_10S = PERIOD_10S * CLK_HZ,
	parameter longint TICKS_15S = PERIOD_15S * CLK_HZ,
	parameter longint TICKS_30S = PERIOD_30S * CLK_HZ,
	parameter longint TICKS_40S = PERIOD_40S * CLK_HZ
) (
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	input  wire logic              clk_en,
	input  wire logic              run,
	input  wire logic              restart,
	input  wire logic [CODE_W-1:0] code,
	output logic                   expired
);

	logic [CNT_W-1:0] count_reg;
	logic [CNT_W-1:0] count_next;
	logic [CNT_W-1:0] limit_reg;
	logic [CNT_W-1:0] limit_next;
	logic [CNT_W-1:0] limit_sel;

	// Period length for a selection code
	always_comb begin
		case (code)
			CODE_2S:  limit_sel = CNT_W'(TICKS_2S - 1);
			CODE_5S:  limit_sel = CNT_W'(TICKS_5S - 1);
			CODE_10S: limit_sel = CNT_W'(TICKS_10S - 1);
			CODE_15S: limit_sel = CNT_W'(TICKS_15S - 1);
			CODE_30S: limit_sel = CNT_W'(TICKS_30S - 1);
			default:  limit_sel = CNT_W'(TICKS_40S - 1);
		endcase
	end

	// Count up; limit latched only while stopped or when the period restarts
	always_comb begin
		expired    = run && !restart && (count_reg == limit_reg);
		count_next = count_reg;
		limit_next = limit_reg;
		if (!run || restart || expired) begin
			count_next = '0;
			limit_next = limit_sel;
		end else begin
			count_next = count_reg + CNT_W'(1);
		end
	end

	// State registers
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			count_reg <= '0;
			limit_reg <= CNT_W'(TICKS_5S - 1);
		end else if (clk_en) begin
			count_reg <= count_next;
			limit_reg <= limit_next;
		end
	end

endmodule

// file: command_driven_watchdog.sv
`timescale 1ns/1ps
module command_driven_watchdog
	import watchdog_pkg::*;
#(
	parameter longint TICKS_2S  = PERIOD_2S * CLK_HZ,
	parameter longint TICKS_5S  = PERIOD_5S * CLK_HZ,
	parameter longint TICKS_10S = PERIOD_10S * CLK_HZ,
	parameter longint TICKS_15S = PERIOD_15S * CLK_HZ,
	parameter longint TICKS_30S = PERIOD_30S * CLK_HZ,
	parameter longint TICKS_40S = PERIOD_40S * CLK_HZ
) (
	input  wire logic        sys_clk,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	input  wire command_t    cmd,
	output reply_t           reply,
	output logic             armed,
	output logic             host_kick_mode,
	output logic             system_reset
);

	//--------------------------------------------------------------
	// State
	//--------------------------------------------------------------
	wd_state_t           state_reg;
	wd_state_t           state_next;
	logic [CODE_W-1:0]   code_reg;
	logic [CODE_W-1:0]   code_next;
	reply_t              reply_reg;
	reply_t              reply_next;
	logic [PULSE_W-1:0]  pulse_reg;
	logic [PULSE_W-1:0]  pulse_next;
	logic                rst_out_reg;
	logic                rst_out_next;
	logic                armed_reg;
	logic                armed_next;
	logic                mode_reg;
	logic                mode_next;

	logic                is_arm;
	logic                is_disarm;
	logic                is_kick;
	logic                is_read;
	logic                is_write;
	logic                is_mode;
	logic                run;
	logic                restart;
	logic                expired;

	//--------------------------------------------------------------
	// Command decode
	//--------------------------------------------------------------
	// Codes outside the six are dropped silently
	always_comb begin
		is_arm    = cmd.valid && (cmd.code == ARM_COMMAND);
		is_disarm = cmd.valid && (cmd.code == DISARM_COMMAND);
		is_kick   = cmd.valid && (cmd.code == KICK_COMMAND);
		is_read   = cmd.valid && (cmd.code == READ_PERIOD_COMMAND);
		is_write  = cmd.valid && (cmd.code == WRITE_PERIOD_COMMAND);
		is_mode   = cmd.valid && (cmd.code == HOST_KICK_MODE_COMMAND);
	end

	//--------------------------------------------------------------
	// Period timer
	//--------------------------------------------------------------
	// Counter runs while armed and pulse_reg[0] is clear; arm from idle and kicks restart it
	always_comb begin
		run     = (state_reg != ST_IDLE) && !pulse_reg[0];
		restart = (is_kick && run)
			|| (is_arm && state_reg == ST_IDLE);
	end

	period_counter #(
		.TICKS_2S  (TICKS_2S),
		.TICKS_5S  (TICKS_5S),
		.TICKS_10S (TICKS_10S),
		.TICKS_15S (TICKS_15S),
		.TICKS_30S (TICKS_30S),
		.TICKS_40S (TICKS_40S)
	) u_period (
		.sys_clk (sys_clk),
		.rst_b   (rst_b),
		.clk_en  (clk_en),
		.run     (run),
		.restart (restart),
		.code    (code_reg),
		.expired (expired)
	);

	//--------------------------------------------------------------
	// Mode control
	//--------------------------------------------------------------
	// Arm, disarm and mode selection; expiry handling per mode
	always_comb begin
		state_next   = state_reg;
		pulse_next   = '0;
		rst_out_next = 1'b0;
		case (state_reg)
			ST_IDLE: begin
				if (is_arm) begin
					state_next = ST_SELF;
				end
			end
			ST_SELF: begin
				// Expiry simply restarts inside the counter
				if (is_disarm) begin
					state_next = ST_IDLE;
				end else if (is_mode) begin
					state_next = ST_HOST;
				end
			end
			ST_HOST: begin
				if (is_disarm) begin
					state_next = ST_IDLE;
				end else if (expired) begin
					state_next = ST_IDLE;
					pulse_next = PULSE_W'(RESET_PULSE_CYC);
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
		if (pulse_reg != '0) begin
			pulse_next   = pulse_reg - PULSE_W'(1);
			rst_out_next = 1'b1;
		end
		armed_next = (state_next != ST_IDLE);
		mode_next  = (state_next == ST_HOST);
	end

	//--------------------------------------------------------------
	// Period selection and read-back
	//--------------------------------------------------------------
	// Store written code; answer a read one cycle later
	always_comb begin
		code_next        = code_reg;
		reply_next.valid = is_read;
		reply_next.data  = code_reg;
		if (is_write) begin
			code_next = cmd.data;
		end
	end

	//--------------------------------------------------------------
	// Registers
	//--------------------------------------------------------------
	// All state frozen while clk_en is low
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg   <= ST_IDLE;
			code_reg    <= CODE_RESET;
			reply_reg   <= '0;
			pulse_reg   <= '0;
			rst_out_reg <= 1'b0;
			armed_reg   <= 1'b0;
			mode_reg    <= 1'b0;
		end else if (clk_en) begin
			state_reg   <= state_next;
			code_reg    <= code_next;
			reply_reg   <= reply_next;
			pulse_reg   <= pulse_next;
			rst_out_reg <= rst_out_next;
			armed_reg   <= armed_next;
			mode_reg    <= mode_next;
		end
	end

	assign reply          = reply_reg;
	assign armed          = armed_reg;
	assign host_kick_mode = mode_reg;
	assign system_reset   = rst_out_reg;

endmodule

// file: command_driven_watchdog_properties.sv
`timescale 1ns/1ps
module watchdog_checker
	import watchdog_pkg::*;
(
	input wire logic     sys_clk,
	input wire logic     rst_b,
	input wire logic     clk_en,
	input wire command_t cmd,
	input wire reply_t   reply,
	input wire logic     armed,
	input wire logic     host_kick_mode,
	input wire logic     system_reset
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	logic       take;
	logic       rd_take;
	logic       wr_take;
	logic [4:0] len_reg;
	// Commands taken at this edge
	assign take    = cmd.valid && clk_en;
	assign rd_take = take && cmd.code == READ_PERIOD_COMMAND;
	assign wr_take = take && cmd.code == WRITE_PERIOD_COMMAND;
	// Length of the running reset pulse
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			len_reg <= 5'h00;
		else if (system_reset && clk_en)
			len_reg <= len_reg + 5'h01;
		else if (!system_reset)
			len_reg <= 5'h00;
	end
	//----------------------------------------------------------
	// Properties
	//----------------------------------------------------------
	arm_takes_a: assert property (take && cmd.code == ARM_COMMAND |=> armed)
		else $error("arm command did not arm");
	disarm_takes_a: assert property (take && cmd.code == DISARM_COMMAND |=> !armed && !host_kick_mode)
		else $error("disarm command left watchdog armed");
	read_answers_a: assert property (rd_take |=> reply.valid)
		else $error("read command got no reply");
	reply_cause_a: assert property (reply.valid |-> $past(rd_take))
		else $error("reply without a read command");
	write_stores_a: assert property (wr_take |-> ##2 reply.data == $past(cmd.data, 2))
		else $error("written code not stored");
	mode_needs_arm_a: assert property ($rose(host_kick_mode) |-> armed && $past(armed))
		else $error("host kick mode entered while disarmed");
	reset_cause_a: assert property ($rose(system_reset) |-> $past(host_kick_mode) || $past(host_kick_mode, 2))
		else $error("reset pulse outside host kick mode");
	reset_width_a: assert property ($fell(system_reset) |-> len_reg == 5'h0A)
		else $error("reset pulse has wrong width");
	idle_kick_a: assert property (take && cmd.code == KICK_COMMAND && !armed |=> !armed)
		else $error("kick while disarmed armed the watchdog");
	arm_seen_c: cover property ($rose(armed));
	reset_seen_c: cover property ($rose(system_reset));
	reply_seen_c: cover property (reply.valid);
endmodule

// file: host_model.sv
`timescale 1ns/1ps
module host_model
	import watchdog_pkg::*;
(
	input  wire logic sys_clk,
	output command_t  cmd
);
	// Bus idle at time zero
	initial cmd = '0;
	// One command strobe; released fields are scrambled, not held
	task automatic send(input logic [11:0] code, input logic [2:0] data);
		@(negedge sys_clk);
		cmd = {1'b1, code, data};
		@(negedge sys_clk);
		cmd = {1'b0, ~code, ~data};
	endtask
	// Kicks spaced so each lands inside the period
	task automatic kicks(input int n, input int gap);
		repeat (n) begin
			send(KICK_COMMAND, 3'h0);
			repeat (gap) @(negedge sys_clk);
		end
	endtask
endmodule

// file: tb_command_driven_watchdog.sv
`timescale 1ns/1ps
module tb_command_driven_watchdog
	import watchdog_pkg::*;
;
	localparam int LIMIT = 20000;
	logic     sys_clk;
	logic     rst_b;
	logic     clk_en;
	command_t cmd;
	reply_t   reply;
	logic     armed;
	logic     host_kick_mode;
	logic     system_reset;
	logic     seen_rst = 1'b0;
	int       failures = 0;
	int       total_checks = 0;
	int       cycles = 0;

	command_driven_watchdog #(.TICKS_2S(20), .TICKS_5S(50), .TICKS_10S(100),
		.TICKS_30S(300), .TICKS_40S(400)) dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
		.clk_en(clk_en), .cmd(cmd), .reply(reply), .armed(armed),
		.host_kick_mode(host_kick_mode), .system_reset(system_reset));
	host_model host_u (.sys_clk(sys_clk), .cmd(cmd));

	// Clock and hang guard
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (system_reset === 1'b1) seen_rst = 1'b1;
		if (cycles == LIMIT) begin
			failures++;
			complete_run();
		end
	end
	//----------------------------------------------------------
	// Checks and scenarios
	//----------------------------------------------------------
	task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic rd_chk(input logic [2:0] exp);
		host_u.send(READ_PERIOD_COMMAND, 3'h0);
		chk("reply valid", 4'h1, reply.valid);
		chk("reply data", {1'b0, exp}, reply.data);
	endtask
	task automatic t_reset();
		chk("armed at reset", 4'h0, armed);
		chk("mode at reset", 4'h0, host_kick_mode);
		rd_chk(CODE_RESET);
		$display("test reset done");
	endtask
	task automatic t_codes();
		for (int i = 0; i < 8; i++) begin
			host_u.send(WRITE_PERIOD_COMMAND, 3'(i));
			rd_chk(3'(i));
		end
		$display("test codes done");
	endtask
	task automatic t_self();
		host_u.send(WRITE_PERIOD_COMMAND, CODE_2S);
		host_u.send(ARM_COMMAND, 3'h0);
		seen_rst = 1'b0;
		chk("armed", 4'h1, armed);
		repeat (70) @(negedge sys_clk);
		chk("self reset", 4'h0, seen_rst);
		chk("still armed", 4'h1, armed);
		host_u.send(DISARM_COMMAND, 3'h0);
		chk("disarmed", 4'h0, armed);
		$display("test self service done");
	endtask
	task automatic t_host(input logic [2:0] code, input int ticks);
		int n;
		n = 0;
		host_u.send(WRITE_PERIOD_COMMAND, code);
		host_u.send(ARM_COMMAND, 3'h0);
		host_u.send(HOST_KICK_MODE_COMMAND, 3'h0);
		seen_rst = 1'b0;
		chk("mode", 4'h1, host_kick_mode);
		host_u.kicks(4, ticks - 6);
		chk("early reset", 4'h0, seen_rst);
		while (system_reset !== 1'b1 && n < 30) begin
			@(negedge sys_clk);
			n++;
		end
		chk("expiry time", 4'h1, n >= 5 && n <= 10);
		chk("armed after expiry", 4'h0, armed);
		repeat (12) @(negedge sys_clk);
		$display("test host mode code %0d done", code);
	endtask
	task automatic t_disarm();
		host_u.send(WRITE_PERIOD_COMMAND, CODE_2S);
		host_u.send(HOST_KICK_MODE_COMMAND, 3'h0);
		chk("mode while idle", 4'h0, host_kick_mode);
		host_u.send(KICK_COMMAND, 3'h0);
		chk("kick while idle", 4'h0, armed);
		clk_en = 1'b0;
		host_u.send(ARM_COMMAND, 3'h0);
		chk("frozen arm", 4'h0, armed);
		clk_en = 1'b1;
		host_u.send(ARM_COMMAND, 3'h0);
		host_u.send(HOST_KICK_MODE_COMMAND, 3'h0);
		host_u.send(DISARM_COMMAND, 3'h0);
		seen_rst = 1'b0;
		chk("mode cleared", 4'h0, host_kick_mode);
		repeat (50) @(negedge sys_clk);
		chk("reset after disarm", 4'h0, seen_rst);
		$display("test disarm done");
	endtask
	task automatic complete_run();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		rst_b = 1'b0;
		clk_en = 1'b1;
		repeat (20) @(negedge sys_clk);
		rst_b = 1'b1;
		t_reset();
		t_codes();
		t_self();
		t_host(3'h0, 20);
		t_host(3'h2, 100);
		t_host(3'h6, 400);
		t_disarm();
		complete_run();
	end
endmodule

bind command_driven_watchdog watchdog_checker chk_u (.sys_clk(sys_clk), .rst_b(rst_b),
	.clk_en(clk_en), .cmd(cmd), .reply(reply), .armed(armed),
	.host_kick_mode(host_kick_mode), .system_reset(system_reset));
